/* fsp_pkg.sv */
// Contract
// - flash splits into boot, general, config segments
// - config segment holds config words at top
// - security word sets protect level and write-protect
// - boot limit counts pages of 1024 words
// - smallest boot segment is one page
// - alternate table fills last boot page
// - alternate table forces two-page minimum
// - boot write-protect skips alternate table page
// - boot code may rewrite last boot page outside the primary table
// - general segment follows boot, excludes config
// - primary table takes general security without boot
// - primary table write-locked if boot or general segment write-protected
// - general protection works without a boot segment
package fsp_pkg;
  // geometry
  localparam int unsigned PAGE_WORDS = 1024;
  localparam int unsigned PAGE_SHIFT = 10;
  localparam int unsigned IVT_WORDS  = 512;
  localparam int unsigned LIM_W      = 13;
  localparam logic [12:0] MIN_PAGES     = 13'h0001;
  localparam logic [12:0] MIN_PAGES_ALT = 13'h0002;

  // register byte offsets
  localparam logic [7:0] OFS_SEC  = 8'h00;
  localparam logic [7:0] OFS_BLIM = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DENY = 8'h0C;

  // security_config_word fields
  localparam int unsigned SEC_W       = 6;
  localparam int unsigned SEC_BOOT_WP = 0;
  localparam int unsigned SEC_BOOT_CP = 1;
  localparam int unsigned SEC_GEN_WP  = 2;
  localparam int unsigned SEC_GEN_CP  = 3;
  localparam int unsigned SEC_CFG_WP  = 4;
  localparam int unsigned SEC_CFG_CP  = 5;
  localparam logic [5:0]  SEC_RST     = 6'h00;

  // boot_limit_config_word fields
  localparam int unsigned BLIM_ALT_BIT = 16;
  localparam logic [12:0] BLIM_RST     = 13'h0000;

  // status fields
  localparam int unsigned STAT_DENY_BIT = 2;
  localparam int unsigned STAT_BOOT_BIT = 3;
  localparam int unsigned CNT_W         = 16;

  typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE} fsp_op_t;
  typedef enum logic [1:0] {SEG_BOOT, SEG_GEN, SEG_CFG} fsp_seg_t;
  typedef enum logic [1:0] {SRC_BOOT, SRC_GEN, SRC_EXT} fsp_src_t;
endpackage

/* fsp_classify.sv */
`timescale 1ns/100ps
module fsp_classify import fsp_pkg::*; #(
  parameter int unsigned ADDR_W      = 24,
  parameter int unsigned FLASH_PAGES = 32,
  parameter int unsigned CFG_WORDS   = 64
) (
  input  logic [ADDR_W-1:0] addr_in,
  input  logic [12:0]       bound_in,
  input  logic              alt_en_in,
  output fsp_seg_t          seg_out,
  output logic              ivt_out,
  output logic              last_boot_out,
  output logic              alt_page_out
);
  localparam int unsigned PG_W = ADDR_W - PAGE_SHIFT;
  localparam logic [ADDR_W-1:0] CFG_BASE =
    ADDR_W'(FLASH_PAGES * PAGE_WORDS - CFG_WORDS);

  logic [PG_W-1:0] page;
  logic [PG_W-1:0] bound;
  logic            cfg_hit;

  // config base first, then page index against the boot limit, decides the segment
  assign page    = addr_in[ADDR_W-1:PAGE_SHIFT];
  assign bound   = PG_W'(bound_in);
  assign cfg_hit = addr_in >= CFG_BASE;

  always_comb begin
    if (cfg_hit) begin
      seg_out = SEG_CFG;
    end else if (page < bound) begin
      seg_out = SEG_BOOT;
    end else begin
      seg_out = SEG_GEN;
    end
  end

  // last boot page, and the alternate table page when enabled
  assign last_boot_out = (bound != '0) && (page == bound - PG_W'(1));
  assign alt_page_out  = alt_en_in && last_boot_out;
  assign ivt_out       = addr_in < ADDR_W'(IVT_WORDS);
endmodule // fsp_classify

/* fsp_guard.sv */
`timescale 1ns/100ps
module fsp_guard import fsp_pkg::*; #(
  parameter int unsigned ADDR_W      = 24,
  parameter int unsigned FLASH_PAGES = 32,
  parameter int unsigned CFG_WORDS   = 64
) (
  input  logic              clk_in,
  input  logic              nrst_in,
  // apb slave
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [7:0]        paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // flash access request
  input  logic              req_valid_in,
  input  fsp_op_t           req_op_in,
  input  fsp_src_t          req_src_in,
  input  logic [ADDR_W-1:0] req_addr_in,
  // decision
  output logic              resp_valid_out,
  output logic              resp_grant_out,
  output fsp_seg_t          resp_seg_out
);
  localparam logic [ADDR_W-1:0] CFG_BASE =
    ADDR_W'(FLASH_PAGES * PAGE_WORDS - CFG_WORDS);

  // configuration and status state
  logic [SEC_W-1:0] sec_r, sec_nxt;
  logic [12:0]      lim_r, lim_nxt;
  logic             alt_r, alt_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic             last_deny_r, last_deny_nxt;
  fsp_seg_t         last_seg_r, last_seg_nxt;

  // apb answer state
  logic             rdy_r, rdy_nxt;
  logic             err_r, err_nxt;
  logic [31:0]      rd_r, rd_nxt;

  // decision state
  logic             rv_r, rv_nxt;
  logic             rg_r, rg_nxt;
  fsp_seg_t         rs_r, rs_nxt;

  // combinational helpers
  logic [12:0] eff_pages;
  logic        boot_on;
  fsp_seg_t    seg;
  logic        is_ivt;
  logic        is_last;
  logic        is_alt;
  logic        is_wr;
  logic        wr_deny;
  logic        rd_deny;
  logic        deny;
  logic        apb_acc;
  logic        apb_fin;
  logic        mapped;
  logic        clr_cnt;

  logic boot_wp, boot_cp, gen_wp, gen_cp, cfg_wp, cfg_cp;
  assign boot_wp = sec_r[SEC_BOOT_WP];
  assign boot_cp = sec_r[SEC_BOOT_CP];
  assign gen_wp  = sec_r[SEC_GEN_WP];
  assign gen_cp  = sec_r[SEC_GEN_CP];
  assign cfg_wp  = sec_r[SEC_CFG_WP];
  assign cfg_cp  = sec_r[SEC_CFG_CP];

  // boot size: zero disables it, else clamp to the minimum
  // so a too-small limit cannot strip the primary table
  always_comb begin
    if (lim_r == '0) begin
      eff_pages = '0;
    end else if (alt_r && lim_r < MIN_PAGES_ALT) begin
      eff_pages = MIN_PAGES_ALT;
    end else if (lim_r < MIN_PAGES) begin
      eff_pages = MIN_PAGES;
    end else begin
      eff_pages = lim_r;
    end
  end
  assign boot_on = eff_pages != '0;

  fsp_classify #(
    .ADDR_W      (ADDR_W),
    .FLASH_PAGES (FLASH_PAGES),
    .CFG_WORDS   (CFG_WORDS)
  ) u_cls (
    .addr_in       (req_addr_in),
    .bound_in      (eff_pages),
    .alt_en_in     (alt_r),
    .seg_out       (seg),
    .ivt_out       (is_ivt),
    .last_boot_out (is_last),
    .alt_page_out  (is_alt)
  );

  assign is_wr = req_op_in != OP_READ;

  // program/erase check; the primary table is checked first
  always_comb begin
    wr_deny = 1'b0;
    if (is_ivt) begin
      wr_deny = boot_wp | gen_wp;
    end else begin
      unique case (seg)
        SEG_BOOT: begin
          if (is_last && req_src_in == SRC_BOOT) begin
            wr_deny = 1'b0;
          end else if (is_alt) begin
            wr_deny = 1'b0;
          end else begin
            wr_deny = boot_wp;
          end
        end
        SEG_GEN: wr_deny = gen_wp;
        SEG_CFG: wr_deny = cfg_wp;
        default: wr_deny = 1'b1;
      endcase
    end
  end

  // read check: boot code may read everything below it;
  // the primary table follows boot security only if boot on
  always_comb begin
    rd_deny = 1'b0;
    if (is_ivt && !boot_on) begin
      rd_deny = gen_cp && req_src_in == SRC_EXT;
    end else if (is_ivt) begin
      rd_deny = boot_cp && req_src_in != SRC_BOOT;
    end else begin
      unique case (seg)
        SEG_BOOT: rd_deny = boot_cp && req_src_in != SRC_BOOT;
        SEG_GEN:  rd_deny = gen_cp && req_src_in == SRC_EXT;
        SEG_CFG:  rd_deny = cfg_cp && req_src_in == SRC_EXT;
        default:  rd_deny = 1'b1;
      endcase
    end
  end

  assign deny = is_wr ? wr_deny : rd_deny;

  // decision registers: one answer per request, next cycle
  always_comb begin
    rv_nxt = req_valid_in;
    rg_nxt = req_valid_in && !deny;
    rs_nxt = req_valid_in ? seg : rs_r;
    if (req_valid_in && is_ivt) begin
      rs_nxt = boot_on ? SEG_BOOT : SEG_GEN;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rv_r <= 1'b0;
      rg_r <= 1'b0;
      rs_r <= SEG_GEN;
    end else begin
      rv_r <= rv_nxt;
      rg_r <= rg_nxt;
      rs_r <= rs_nxt;
    end
  end

  // apb: ready one cycle into the access phase, so the
  // access always takes two cycles; writes land with it
  assign apb_acc = psel && penable && !rdy_r;
  assign apb_fin = psel && penable && rdy_r;
  assign mapped  = paddr == OFS_SEC || paddr == OFS_BLIM ||
                   paddr == OFS_STAT || paddr == OFS_DENY;
  assign clr_cnt = apb_fin && pwrite && paddr == OFS_DENY;

  always_comb begin
    rdy_nxt = apb_acc;
    err_nxt = apb_acc && !mapped;
    rd_nxt  = rd_r;
    if (apb_acc) begin
      rd_nxt = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          OFS_SEC:  rd_nxt[SEC_W-1:0] = sec_r;
          OFS_BLIM: begin
            rd_nxt[LIM_W-1:0]       = lim_r;
            rd_nxt[BLIM_ALT_BIT]    = alt_r;
          end
          OFS_STAT: begin
            rd_nxt[1:0]             = last_seg_r;
            rd_nxt[STAT_DENY_BIT]   = last_deny_r;
            rd_nxt[STAT_BOOT_BIT]   = boot_on;
          end
          OFS_DENY: rd_nxt[CNT_W-1:0] = cnt_r;
          default:  rd_nxt = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rd_r  <= 32'h0000_0000;
    end else begin
      rdy_r <= rdy_nxt;
      err_r <= err_nxt;
      rd_r  <= rd_nxt;
    end
  end

  // config words and status; a denial in the clearing
  // cycle is still counted so no event is lost
  always_comb begin
    sec_nxt       = sec_r;
    lim_nxt       = lim_r;
    alt_nxt       = alt_r;
    cnt_nxt       = cnt_r;
    last_deny_nxt = last_deny_r;
    last_seg_nxt  = last_seg_r;
    if (apb_fin && pwrite) begin
      if (paddr == OFS_SEC) begin
        sec_nxt = pwdata[SEC_W-1:0];
      end
      if (paddr == OFS_BLIM) begin
        lim_nxt = pwdata[LIM_W-1:0];
        alt_nxt = pwdata[BLIM_ALT_BIT];
      end
    end
    if (clr_cnt) begin
      cnt_nxt = '0;
    end
    if (req_valid_in) begin
      last_deny_nxt = deny;
      last_seg_nxt  = seg;
      if (deny && cnt_r != '1) begin
        cnt_nxt = clr_cnt ? CNT_W'(1) : cnt_r + CNT_W'(1);
      end else if (deny) begin
        cnt_nxt = clr_cnt ? CNT_W'(1) : cnt_r;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sec_r       <= SEC_RST;
      lim_r       <= BLIM_RST;
      alt_r       <= 1'b0;
      cnt_r       <= '0;
      last_deny_r <= 1'b0;
      last_seg_r  <= SEG_GEN;
    end else begin
      sec_r       <= sec_nxt;
      lim_r       <= lim_nxt;
      alt_r       <= alt_nxt;
      cnt_r       <= cnt_nxt;
      last_deny_r <= last_deny_nxt;
      last_seg_r  <= last_seg_nxt;
    end
  end

  assign prdata         = rd_r;
  assign pready         = rdy_r;
  assign pslverr        = err_r;
  assign resp_valid_out = rv_r;
  assign resp_grant_out = rg_r;
  assign resp_seg_out   = rs_r;

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  logic wr_req;
  assign wr_req = req_valid_in && is_wr;

  sequence s_deny_next;
    resp_valid_out && !resp_grant_out;
  endsequence

  sequence s_grant_next;
    resp_valid_out && resp_grant_out;
  endsequence

  sequence s_apb_answer;
    pready ##1 !pready;
  endsequence

  chk_ivt_lock: assert property (
    wr_req && is_ivt && (boot_wp || gen_wp) |=> s_deny_next)
    else $error("primary table write not blocked");

  chk_last_page: assert property (
    wr_req && !is_ivt && seg == SEG_BOOT && is_last &&
    req_src_in == SRC_BOOT |=> s_grant_next)
    else $error("boot code refused on last boot page");

  chk_alt_open: assert property (
    wr_req && !is_ivt && seg == SEG_BOOT && is_alt
    |=> s_grant_next)
    else $error("alternate table page write-protected");

  // the alternate table page must never fall on page 0
  chk_alt_min: assert property (
    req_valid_in && is_alt |-> req_addr_in[ADDR_W-1:PAGE_SHIFT] != '0)
    else $error("alternate table shares the primary table page");

  chk_gen_wp: assert property (
    wr_req && !is_ivt && seg == SEG_GEN && gen_wp
    |=> s_deny_next)
    else $error("general write not refused");

  chk_ivt_sec: assert property (
    req_valid_in && !is_wr && is_ivt && !boot_on && gen_cp &&
    req_src_in == SRC_EXT |=> s_deny_next ##0 resp_seg_out == SEG_GEN)
    else $error("primary table not under general security");

  chk_boot_read: assert property (
    req_valid_in && !is_wr && !is_ivt && seg == SEG_BOOT &&
    boot_cp && req_src_in != SRC_BOOT |=> s_deny_next)
    else $error("protected boot read granted");

  chk_cfg_top: assert property (
    req_valid_in && seg == SEG_CFG |-> req_addr_in >= CFG_BASE)
    else $error("config segment below top of flash");

  chk_apb_two: assert property (
    psel && penable && !pready |=> s_apb_answer)
    else $error("apb answer not one cycle into access");

  chk_cnt_keep: assert property (
    clr_cnt && req_valid_in && deny |=> cnt_r == CNT_W'(1))
    else $error("denial lost while clearing count");
endmodule // fsp_guard

/* fsp_req_model.sv */
`timescale 1ns/100ps
module fsp_req_model import fsp_pkg::*; (
  input  wire logic        clk_in,
  output logic             req_valid_out,
  output fsp_op_t          req_op_out,
  output fsp_src_t         req_src_out,
  output logic [23:0]      req_addr_out
);
  // idle address flips so a stale value never looks like a live one
  initial begin
    req_valid_out = 1'b0;
    req_op_out = OP_READ;
    req_src_out = SRC_EXT;
    req_addr_out = 24'h000000;
  end

  // one strobe cycle per request, after some idle edges
  task automatic issue(input fsp_op_t op, input fsp_src_t src,
                       input logic [23:0] a, input int idle);
    repeat (idle) @(posedge clk_in);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_op_out <= op;
    req_src_out <= src;
    req_addr_out <= a;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_addr_out <= ~a;
  endtask
endmodule // fsp_req_model

/* testbench.sv */
`timescale 1ns/100ps
module testbench import fsp_pkg::*;;
  logic        clk_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        req_v;
  fsp_op_t     req_op;
  fsp_src_t    req_src;
  logic [23:0] req_addr;
  logic        resp_valid_out;
  logic        resp_grant_out;
  fsp_seg_t    resp_seg_out;
  int          fails = 0;
  int          checked = 0;
  int          denies = 0;

  always #2 clk_in = ~clk_in;

  fsp_req_model u_req (.clk_in(clk_in), .req_valid_out(req_v),
    .req_op_out(req_op), .req_src_out(req_src), .req_addr_out(req_addr));

  fsp_guard u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_valid_in(req_v), .req_op_in(req_op), .req_src_in(req_src),
    .req_addr_in(req_addr), .resp_valid_out(resp_valid_out),
    .resp_grant_out(resp_grant_out), .resp_seg_out(resp_seg_out));

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    checked++;
    if (g !== x) begin
      $display("BAD %s expected %h seen %h", nm, x, g);
      fails++;
    end
  endtask

  // request held until pready is sampled high, released only after
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fails++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic ex);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk("prdata", x, q);
    chk("pslverr", {31'h0, ex}, {31'h0, e});
  endtask

  // decision lands exactly one edge after the strobe is taken
  task automatic acc(input fsp_op_t op, input fsp_src_t src,
                     input logic [23:0] a, input logic g, input fsp_seg_t s);
    u_req.issue(op, src, a, 1);
    @(posedge clk_in);
    chk("resp_valid", 32'h1, {31'h0, resp_valid_out});
    chk("grant", {31'h0, g}, {31'h0, resp_grant_out});
    chk("segment", 32'(s), 32'(resp_seg_out));
    if (!g)
      denies++;
  endtask

  task automatic t_regs();
    rd(OFS_SEC, 32'h0, 1'b0);
    rd(OFS_BLIM, 32'h0, 1'b0);
    rd(8'h10, 32'h0, 1'b1);
    wr(OFS_SEC, 32'h3F);
    rd(OFS_SEC, 32'h3F, 1'b0);
    wr(OFS_BLIM, 32'h11FFF);
    rd(OFS_BLIM, 32'h11FFF, 1'b0);
    acc(OP_PROG, SRC_BOOT, 24'h007FC0, 1'b0, SEG_CFG);
    acc(OP_READ, SRC_EXT, 24'h007FFF, 1'b0, SEG_CFG);
    acc(OP_READ, SRC_GEN, 24'h007FFF, 1'b1, SEG_CFG);
  endtask

  // no boot segment: general protection alone
  task automatic t_gen();
    wr(OFS_SEC, 32'h0C);
    wr(OFS_BLIM, 32'h0);
    acc(OP_PROG, SRC_GEN, 24'h000000, 1'b0, SEG_GEN);
    acc(OP_ERASE, SRC_GEN, 24'h001400, 1'b0, SEG_GEN);
    acc(OP_READ, SRC_EXT, 24'h001400, 1'b0, SEG_GEN);
    acc(OP_READ, SRC_GEN, 24'h001400, 1'b1, SEG_GEN);
    acc(OP_READ, SRC_EXT, 24'h000100, 1'b0, SEG_GEN);
    acc(OP_PROG, SRC_GEN, 24'h007FC0, 1'b1, SEG_CFG);
    acc(OP_PROG, SRC_GEN, 24'h007FBF, 1'b0, SEG_GEN);
    rd(OFS_STAT, 32'h5, 1'b0);
  endtask

  // one-page boot segment, write and read protected
  task automatic t_boot();
    wr(OFS_SEC, 32'h03);
    wr(OFS_BLIM, 32'h1);
    acc(OP_PROG, SRC_GEN, 24'h000000, 1'b0, SEG_BOOT);
    acc(OP_PROG, SRC_BOOT, 24'h000200, 1'b1, SEG_BOOT);
    acc(OP_ERASE, SRC_GEN, 24'h0003FF, 1'b0, SEG_BOOT);
    acc(OP_READ, SRC_GEN, 24'h0003FF, 1'b0, SEG_BOOT);
    acc(OP_READ, SRC_BOOT, 24'h0003FF, 1'b1, SEG_BOOT);
    acc(OP_PROG, SRC_GEN, 24'h000400, 1'b1, SEG_GEN);
    rd(OFS_STAT, 32'h9, 1'b0);
  endtask

  // alternate table page stretches and caps the boot segment
  task automatic t_alt();
    wr(OFS_BLIM, 32'h10001);
    acc(OP_PROG, SRC_GEN, 24'h000400, 1'b1, SEG_BOOT);
    acc(OP_PROG, SRC_GEN, 24'h000800, 1'b1, SEG_GEN);
    wr(OFS_BLIM, 32'h10003);
    acc(OP_PROG, SRC_BOOT, 24'h0007FF, 1'b0, SEG_BOOT);
    acc(OP_ERASE, SRC_EXT, 24'h000BFF, 1'b1, SEG_BOOT);
    acc(OP_PROG, SRC_GEN, 24'h000C00, 1'b1, SEG_GEN);
  endtask

  task automatic t_count();
    rd(OFS_DENY, 32'(denies), 1'b0);
    wr(OFS_DENY, 32'h0);
    rd(OFS_DENY, 32'h0, 1'b0);
    // a denial in the clearing cycle must survive the clear
    fork
      wr(OFS_DENY, 32'h0);
      u_req.issue(OP_READ, SRC_GEN, 24'h000400, 2);
    join
    rd(OFS_DENY, 32'h1, 1'b0);
  endtask

  // mid-run reset returns settings and outputs to idle
  task automatic t_rst();
    @(posedge clk_in);
    nrst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    chk("pready", 32'h0, {31'h0, pready});
    chk("resp_valid", 32'h0, {31'h0, resp_valid_out});
    chk("segment", 32'(SEG_GEN), 32'(resp_seg_out));
    nrst_in <= 1'b1;
    rd(OFS_SEC, 32'h0, 1'b0);
    rd(OFS_BLIM, 32'h0, 1'b0);
    rd(OFS_DENY, 32'h0, 1'b0);
    rd(OFS_STAT, 32'h1, 1'b0);
  endtask

  // hang guard at 10000 cycles, far above the run's length
  initial begin
    #40000;
    fails++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_gen();
    t_boot();
    t_alt();
    t_count();
    t_rst();
    end_sim();
  end
endmodule // testbench
